// file: logic/part_tracker.sv
/*
  tracks how many parts of a split high-bandwidth packet remain to send.
  assumes mult is 1..3 and sends pulse once per in data packet.
*/
`timescale 1ns/1ps
`default_nettype none
module part_tracker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [1:0] mult,
  input wire logic part_sent,
  input wire logic frame_end,
  output logic incomplete,
  output logic last_part
);
  logic [1:0] left;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      left <= 2'h0;
    end else if (start) begin
      left <= mult;
    end else if (frame_end) begin
      left <= 2'h0;
    end else if (part_sent && left != 2'h0) begin
      left <= left - 2'h1;
    end
  end
  // a frame that ends with parts still queued leaves the packet short
  assign incomplete = frame_end && left != 2'h0 && !(part_sent && left == 2'h1);
  assign last_part = part_sent && left == 2'h1;
endmodule
`default_nettype wire

// file: logic/pkt_counter.sv
/*
  small occupancy counter for packets held in the in fifo.
  assumes inc and dec are single-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module pkt_counter (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic inc,
  input wire logic dec,
  input wire logic clr,
  output logic [1:0] count
);
  import usb_ep_pkg::*;
  always_ff @(posedge core_clk) begin
    if (!rst_n || clr) begin
      count <= 2'h0;
    end else if (inc && !dec && count != fifo_depth_pkts) begin
      count <= count + 2'h1;
    end else if (dec && !inc && count != 2'h0) begin
      count <= count - 2'h1;
    end
  end
endmodule
`default_nettype wire

// file: logic/usb_ep_ctrl.sv
/*
  in-endpoint control/status register and out max-payload register.
  assumes an apb master, and usb link events as one-cycle pulses.
*/
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module usb_ep_ctrl (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fifo_shared,
  input wire logic high_speed,
  input wire logic fifo_loaded_max,
  input wire logic in_token,
  input wire logic pkt_sent,
  input wire logic frame_end,
  output logic stall_reply,
  output logic zero_len_reply,
  output logic dma_req,
  output logic tx_done_event,
  output logic fifo_flush,
  output logic data_toggle,
  output logic dir_in,
  output logic [10:0] rx_max_payload,
  output logic [5:0] rx_combine_count,
  output logic rx_hb_iso
);
  import usb_ep_pkg::*;

  typedef struct packed {
    logic [15:0] tx_ctrl_status_reg;
    logic [15:0] rx_endpoint_max_payload_reg;
    logic toggle_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic stall_reply_reg;
    logic zlp_reg;
    logic dma_req_reg;
    logic done_evt_reg;
    logic flush_reg;
    logic dir_in_reg;
    logic [5:0] combine_reg;
    logic hb_iso_reg;
  } state_t;

  state_t s_reg, s_next;
  logic [1:0] pkts;
  logic pc_inc, pc_dec, pc_clr;
  logic pt_incomplete, pt_last;
  logic iso, wr, rd_setup;
  logic hit_csr, hit_maxp, hit_status, hb_now;
  logic [15:0] csr, csr_view;

  assign csr = s_reg.tx_ctrl_status_reg;
  assign iso = csr[b_iso];
  // a write lands at the one edge where pready is seen high
  assign wr = psel && penable && pwrite && s_reg.pready_reg;
  assign hit_csr = paddr == tx_csr_addr;
  assign hit_maxp = paddr == rx_maxp_addr;
  assign hit_status = paddr == status_addr;
  assign rd_setup = psel && !penable;

  pkt_counter u_pkts (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .inc(pc_inc),
    .dec(pc_dec),
    .clr(pc_clr),
    .count(pkts)
  );

  logic [1:0] tx_mult;
  // tx multiplier mirrors the rx register layout for high-bandwidth iso
  assign tx_mult = s_reg.rx_endpoint_max_payload_reg[12] ? 2'h3 :
                   (s_reg.rx_endpoint_max_payload_reg[11] ? 2'h2 : 2'h1);

  part_tracker u_parts (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(pc_inc && iso && high_speed),
    .mult(tx_mult),
    .part_sent(pkt_sent),
    .frame_end(frame_end),
    .incomplete(pt_incomplete),
    .last_part(pt_last)
  );

  assign hb_now = iso && high_speed && tx_mult != 2'h1;

  // read view: commands and unused bits read as zero, partial only in high-bandwidth iso
  always_comb begin
    csr_view = 16'h0000;
    csr_view[15:10] = csr[15:10];
    csr_view[b_partial] = hb_now && csr[b_partial];
    csr_view[b_stall_sent] = csr[b_stall_sent];
    csr_view[b_stall_req] = csr[b_stall_req];
    csr_view[b_underrun] = csr[b_underrun];
    csr_view[b_occupied] = pkts != 2'h0;
    csr_view[b_ready] = csr[b_ready];
  end

  always_comb begin
    logic ready_clear;
    logic sw_ready;
    logic flush_cmd;
    logic stall_now;
    logic hb;
    ready_clear = 1'b0;
    sw_ready = 1'b0;
    flush_cmd = 1'b0;
    stall_now = 1'b0;
    hb = hb_now;
    s_next = s_reg;
    s_next.pready_reg = 1'b0;
    s_next.pslverr_reg = 1'b0;
    s_next.stall_reply_reg = 1'b0;
    s_next.zlp_reg = 1'b0;
    s_next.done_evt_reg = 1'b0;
    s_next.flush_reg = 1'b0;
    s_next.tx_ctrl_status_reg[b_tog_reset] = 1'b0;
    s_next.tx_ctrl_status_reg[b_discard] = 1'b0;
    pc_inc = 1'b0;
    pc_dec = 1'b0;
    pc_clr = 1'b0;
    // apb: pready is raised by the setup edge, so the access phase has no wait state
    if (rd_setup) begin
      s_next.pready_reg = 1'b1;
      if (!hit_csr && !hit_maxp && !hit_status) begin
        s_next.pslverr_reg = 1'b1;
      end
    end
    if (rd_setup) begin
      unique case (paddr)
        tx_csr_addr: s_next.prdata_reg = {16'h0000, csr_view};
        rx_maxp_addr: s_next.prdata_reg = {16'h0000, s_reg.rx_endpoint_max_payload_reg};
        status_addr: s_next.prdata_reg = {30'h0, s_reg.dir_in_reg, s_reg.toggle_reg};
        default: s_next.prdata_reg = 32'h0000_0000;
      endcase
    end
    if (wr && paddr == tx_csr_addr) begin
      s_next.tx_ctrl_status_reg[15:10] = pwdata[15:10];
      s_next.tx_ctrl_status_reg[b_stall_req] = pwdata[b_stall_req];
      // status flags clear on written zero; hardware set below wins
      if (!pwdata[b_partial]) s_next.tx_ctrl_status_reg[b_partial] = 1'b0;
      if (!pwdata[b_stall_sent]) s_next.tx_ctrl_status_reg[b_stall_sent] = 1'b0;
      if (!pwdata[b_underrun]) s_next.tx_ctrl_status_reg[b_underrun] = 1'b0;
      if (pwdata[b_tog_reset]) begin
        s_next.tx_ctrl_status_reg[b_tog_reset] = 1'b1;
        s_next.toggle_reg = 1'b0;
      end
      sw_ready = pwdata[b_ready];
      flush_cmd = pwdata[b_discard];
      if (flush_cmd) s_next.tx_ctrl_status_reg[b_discard] = 1'b1;
    end
    if (wr && paddr == rx_maxp_addr) begin
      s_next.rx_endpoint_max_payload_reg = pwdata[15:0];
    end
    // auto-arm on a full-size load
    if (csr[b_auto_arm] && fifo_loaded_max) sw_ready = 1'b1;
    if (sw_ready && !csr[b_ready]) begin
      s_next.tx_ctrl_status_reg[b_ready] = 1'b1;
      pc_inc = 1'b1;
    end
    // in token handling
    if (in_token) begin
      if (csr[b_stall_req] && !iso) begin
        s_next.stall_reply_reg = 1'b1;
        stall_now = 1'b1;
      end else if (iso && !csr[b_ready] && pkts == 2'h0) begin
        s_next.zlp_reg = 1'b1;
        s_next.tx_ctrl_status_reg[b_underrun] = 1'b1;
      end
    end
    if (stall_now) begin
      s_next.tx_ctrl_status_reg[b_stall_sent] = 1'b1;
      s_next.flush_reg = 1'b1;
      pc_clr = 1'b1;
      ready_clear = csr[b_ready];
      s_next.tx_ctrl_status_reg[b_ready] = 1'b0;
    end
    if (pkt_sent && !stall_now) begin
      if (csr[b_force_flip] || !iso) s_next.toggle_reg = ~s_reg.toggle_reg;
      if (!hb || pt_last) begin
        pc_dec = 1'b1;
        ready_clear = csr[b_ready];
        s_next.tx_ctrl_status_reg[b_ready] = 1'b0;
      end
    end
    // double buffering frees the ready bit once a second slot is free
    if (csr[b_ready] && pkts == 2'h1 && !pkt_sent && !stall_now && !sw_ready) begin
      s_next.tx_ctrl_status_reg[b_ready] = 1'b0;
      ready_clear = 1'b1;
    end
    if (pt_incomplete) begin
      s_next.tx_ctrl_status_reg[b_partial] = 1'b1;
      s_next.flush_reg = 1'b1;
      pc_dec = 1'b1;
    end
    if (flush_cmd) begin
      s_next.flush_reg = 1'b1;
      s_next.tx_ctrl_status_reg[b_ready] = 1'b0;
      pc_dec = 1'b1;
      pc_inc = 1'b0;
      ready_clear = 1'b0;
    end
    s_next.done_evt_reg = ready_clear && !(csr[b_dma_en] && csr[b_dma_sel]);
    s_next.dma_req_reg = csr[b_dma_en] && !csr[b_ready] && pkts != fifo_depth_pkts;
    s_next.dir_in_reg = fifo_shared ? csr[b_dir_in] : 1'b1;
    // multiplier is the stored field plus one, up to 32 combined packets
    s_next.combine_reg = 6'(s_reg.rx_endpoint_max_payload_reg[15:11]) + 6'h1;
    s_next.hb_iso_reg = high_speed && s_reg.rx_endpoint_max_payload_reg[12:11] != 2'h0;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata_reg;
  assign pready = s_reg.pready_reg;
  assign pslverr = s_reg.pslverr_reg;
  assign stall_reply = s_reg.stall_reply_reg;
  assign zero_len_reply = s_reg.zlp_reg;
  assign dma_req = s_reg.dma_req_reg;
  assign tx_done_event = s_reg.done_evt_reg;
  assign fifo_flush = s_reg.flush_reg;
  assign data_toggle = s_reg.toggle_reg;
  assign dir_in = s_reg.dir_in_reg;
  assign rx_max_payload = s_reg.rx_endpoint_max_payload_reg[10:0];
  assign rx_combine_count = s_reg.combine_reg;
  assign rx_hb_iso = s_reg.hb_iso_reg;

  // checks on the logic above; all on the one clock, quiet while in reset
  a_tog_selfclear: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    csr[b_tog_reset] |=> !csr[b_tog_reset]
  ) else $error("toggle reset command did not clear itself");

  a_discard_selfclear: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    csr[b_discard] |=> !csr[b_discard]
  ) else $error("discard command did not clear itself");

  a_stall_flags: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    stall_reply |-> csr[b_stall_sent] && !csr[b_ready] && fifo_flush
  ) else $error("stall reply without flag, flush and ready clear");

  a_stall_token: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    stall_reply |-> $past(in_token) && !$past(iso)
  ) else $error("stall reply without token or in iso mode");

  a_zlp_flag: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    zero_len_reply |-> csr[b_underrun] && !stall_reply
  ) else $error("zero-length reply without underrun flag");

  a_zlp_token: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    zero_len_reply |-> $past(in_token) && $past(iso) && !$past(csr[b_ready])
  ) else $error("zero-length reply outside iso underrun");

  a_dma_req_gate: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    dma_req |-> $past(csr[b_dma_en]) && !$past(csr[b_ready])
  ) else $error("dma request while disabled or armed");

  a_event_mode1: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    tx_done_event |-> !($past(csr[b_dma_en]) && $past(csr[b_dma_sel]))
  ) else $error("done event raised in dma mode 1");

  a_event_on_clear: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    tx_done_event |-> $past(csr[b_ready]) && !csr[b_ready]
  ) else $error("done event without a ready clear");

  a_partial_flush: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    pt_incomplete |=> csr[b_partial] && fifo_flush
  ) else $error("short split packet not flagged and flushed");

  a_stall_empties: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    pc_clr |=> pkts == 2'h0
  ) else $error("stall did not empty the packet count");

  a_flush_ready: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    csr[b_discard] |-> !csr[b_ready] && fifo_flush
  ) else $error("discard left ready set or no flush");

  a_dir_fixed: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !fifo_shared |=> dir_in
  ) else $error("direction bit used on an unshared fifo");

  a_toggle_flip: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (pkt_sent && csr[b_force_flip] && !in_token) |=> data_toggle != $past(data_toggle)
  ) else $error("forced toggle did not flip");

  a_auto_arm: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (csr[b_auto_arm] && fifo_loaded_max && !csr[b_ready] && !wr && !in_token && !pkt_sent)
      |=> csr[b_ready]
  ) else $error("auto-arm did not set ready");

  a_ready_set: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (wr && hit_csr && pwdata[b_ready] && !pwdata[b_discard] && !csr[b_ready] && !in_token
      && !pkt_sent) |=> csr[b_ready]
  ) else $error("software ready write did not set ready");

  a_pkt_count: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (pc_inc && !pc_dec && !pc_clr && pkts == 2'h0) |=> pkts == 2'h1
  ) else $error("loaded packet not counted");

  a_cmd_read_zero: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (pready && hit_csr) |-> prdata[9:8] == 2'h0 && !prdata[b_tog_reset] && !prdata[b_discard]
  ) else $error("command or unused bits read as one");

  a_combine_range: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rx_combine_count <= bulk_combine_max
  ) else $error("combine count above limit");

  a_hb_speed: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !high_speed |=> !rx_hb_iso
  ) else $error("high-bandwidth iso flagged at full speed");
endmodule
`default_nettype wire

// file: logic/usb_ep_pkg.sv
/*
  constants for the in-endpoint control/status and out max-payload block.
  assumes an apb slave at 32-bit words, one clock core_clk at 10 mhz.
*/
// How it works
// - auto-arm sets packet-ready on full packet
// - bit 14 selects isochronous mode
// - bit 13 direction, only if fifo shared
// - bit 12 enables dma requests
// - bit 11 flips toggle every sent packet
// - bit 10 selects dma request mode
// - bit 7 flags incomplete high-bandwidth send
// - writing bit 6 clears data toggle
// - stall sent sets flag, flushes, clears ready
// - bit 4 stalls in tokens, not iso
// - bit 3 flushes next packet, clears ready
// - iso underrun sends zero packet, sets flag
// - bit 1 shows fifo holds a packet
// - packet-ready set by software, cleared by device
// - ready clear raises event unless dma mode 1 or a bit 3 flush
// - bits 10:0 hold max payload bytes
// - upper bits hold multiplier minus one
// - bulk combining merges up to 32 packets
// - iso high-bandwidth bits 11/12, 2 or 3
package usb_ep_pkg;
  localparam logic [11:0] tx_csr_addr = 12'h000;
  localparam logic [11:0] rx_maxp_addr = 12'h004;
  localparam logic [11:0] status_addr = 12'h008;
  localparam int b_auto_arm = 15;
  localparam int b_iso = 14;
  localparam int b_dir_in = 13;
  localparam int b_dma_en = 12;
  localparam int b_force_flip = 11;
  localparam int b_dma_sel = 10;
  localparam int b_partial = 7;
  localparam int b_tog_reset = 6;
  localparam int b_stall_sent = 5;
  localparam int b_stall_req = 4;
  localparam int b_discard = 3;
  localparam int b_underrun = 2;
  localparam int b_occupied = 1;
  localparam int b_ready = 0;
  localparam logic [15:0] tx_csr_reset = 16'h0000;
  localparam logic [15:0] rx_maxp_reset = 16'h0000;
  localparam logic [10:0] max_payload_limit = 11'h400;
  localparam logic [5:0] bulk_combine_max = 6'h20;
  localparam logic [1:0] fifo_depth_pkts = 2'h2;
endpackage

// file: testbench/tb.sv
/*
  self-checking bench for usb_ep_ctrl with an apb master and a usb host model.
  assumes pready comes within a few cycles and one clock of 100 ns.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import usb_ep_pkg::*;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v, q;
  logic fifo_loaded_max, in_token, pkt_sent, stall_reply, zero_len_reply, dma_req;
  logic tx_done_event, fifo_flush, data_toggle, dir_in, rx_hb_iso, go;
  logic fifo_shared, high_speed, frame_end, qerr;
  logic [1:0] gap;
  logic [10:0] rx_max_payload;
  logic [5:0] rx_combine_count;
  int error_cnt, n_tests, cyc, ev, st, zl, fl, i, e0;
  int seed;
  int bits[7] = '{15, 14, 13, 12, 11, 10, 4};
  usb_ep_ctrl i_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fifo_shared(fifo_shared), .high_speed(high_speed),
    .fifo_loaded_max(fifo_loaded_max), .in_token(in_token), .pkt_sent(pkt_sent),
    .frame_end(frame_end), .stall_reply(stall_reply), .zero_len_reply(zero_len_reply),
    .dma_req(dma_req), .tx_done_event(tx_done_event), .fifo_flush(fifo_flush),
    .data_toggle(data_toggle), .dir_in(dir_in), .rx_max_payload(rx_max_payload),
    .rx_combine_count(rx_combine_count), .rx_hb_iso(rx_hb_iso));
  usb_host_model i_host (.core_clk(core_clk), .rst_n(rst_n), .go(go), .gap(gap),
    .stall_reply(stall_reply), .zero_len_reply(zero_len_reply), .in_token(in_token),
    .pkt_sent(pkt_sent));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // event counters stand in for the model of one-cycle outputs
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (rst_n) begin
      ev <= ev + tx_done_event;
      st <= st + stall_reply;
      zl <= zl + zero_len_reply;
      fl <= fl + fifo_flush;
    end
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    qerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic csr_is(input logic [31:0] e);
    apb(1'b0, tx_csr_addr, 32'h0);
    chk(q, e);
  endtask
  task automatic token();
    go <= 1'b1;
    gap <= 2'($random(seed));
    @(posedge core_clk);
    go <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    seed = 32'hf44c655e;
    {error_cnt, n_tests, cyc, ev, st, zl, fl} = '0;
    {rst_n, psel, penable, pwrite, go, fifo_loaded_max} = '0;
    {fifo_shared, high_speed, frame_end} = 3'h6;
    paddr = 12'h000;
    pwdata = 32'h0;
    gap = 2'h0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    csr_is({16'h0, tx_csr_reset});
    apb(1'b0, rx_maxp_addr, 32'h0);
    chk(q, {16'h0, rx_maxp_reset});
    chk({31'h0, qerr}, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk({31'h0, qerr}, 32'h1);
    $display("reset test done");
    for (i = 0; i < 4; i++) begin
      high_speed <= i[0];
      v = $random(seed) & 32'h07ff;
      if (v > 32'h400) v = 32'h400;
      v = v | (i << 11);
      apb(1'b1, rx_maxp_addr, v);
      apb(1'b0, rx_maxp_addr, 32'h0);
      chk(q, v);
      chk({21'h0, rx_max_payload}, {21'h0, v[10:0]});
      chk({26'h0, rx_combine_count}, i + 1);
      chk({31'h0, rx_hb_iso}, {31'h0, i[0]});
    end
    high_speed <= 1'b1;
    apb(1'b1, rx_maxp_addr, 32'h0);
    $display("payload test done");
    // mode bits one at a time; the request mode is only dropped with enable already clear
    foreach (bits[k]) begin
      apb(1'b1, tx_csr_addr, 32'h1 << bits[k]);
      csr_is(32'h1 << bits[k]);
      chk({31'h0, dir_in}, {31'h0, bits[k] == 13});
      chk({31'h0, dma_req}, {31'h0, bits[k] == 12});
    end
    fifo_shared <= 1'b0;
    apb(1'b1, tx_csr_addr, 32'h0000);
    chk({31'h0, dir_in}, 32'h1);
    fifo_shared <= 1'b1;
    apb(1'b1, tx_csr_addr, 32'h0040);
    csr_is(32'h0);
    chk({31'h0, data_toggle}, 32'h0);
    // double buffered: a lone packet frees ready at once, a second one keeps it set
    e0 = ev;
    apb(1'b1, tx_csr_addr, 32'h0801);
    csr_is(32'h0802);
    apb(1'b1, tx_csr_addr, 32'h0801);
    csr_is(32'h0803);
    token();
    csr_is(32'h0802);
    chk({31'h0, data_toggle}, 32'h1);
    chk(ev - e0, 2);
    token();
    csr_is(32'h0800);
    chk({31'h0, data_toggle}, 32'h0);
    apb(1'b1, tx_csr_addr, 32'h1401);
    token();
    chk(ev - e0, 2);
    apb(1'b1, tx_csr_addr, 32'h0400);
    apb(1'b1, tx_csr_addr, 32'h0010);
    e0 = st;
    token();
    chk(st > e0, 1);
    csr_is(32'h0030);
    apb(1'b1, tx_csr_addr, 32'h0001);
    e0 = fl;
    apb(1'b1, tx_csr_addr, 32'h0009);
    csr_is(32'h0);
    chk(fl > e0, 1);
    $display("handshake test done");
    apb(1'b1, tx_csr_addr, 32'h4010);
    e0 = st;
    i = zl;
    token();
    chk(st - e0, 0);
    chk(zl > i, 1);
    csr_is(32'h4014);
    // two-part split packet, one part sent, then the microframe ends
    apb(1'b1, rx_maxp_addr, 32'h0800);
    apb(1'b1, tx_csr_addr, 32'h4001);
    token();
    frame_end <= 1'b1;
    @(posedge core_clk);
    frame_end <= 1'b0;
    csr_is(32'h4080);
    apb(1'b1, rx_maxp_addr, 32'h0);
    apb(1'b1, tx_csr_addr, 32'h8000);
    fifo_loaded_max <= 1'b1;
    @(posedge core_clk);
    fifo_loaded_max <= 1'b0;
    @(posedge core_clk);
    csr_is(32'h8002);
    token();
    csr_is(32'h8000);
    $display("iso and auto-arm test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// file: testbench/usb_host_model.sv
/*
  usb host seen from the in endpoint: sends in tokens and reports sent packets.
  assumes go is a one-cycle pulse from the bench and replies are one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [1:0] gap,
  input wire logic stall_reply,
  input wire logic zero_len_reply,
  output logic in_token,
  output logic pkt_sent
);
  int cnt;
  logic refused;
  initial begin
    in_token = 1'b0;
    pkt_sent = 1'b0;
    refused = 1'b0;
    cnt = 0;
  end
  // gap lets the host answer promptly or slowly
  always @(posedge core_clk) begin
    in_token <= 1'b0;
    pkt_sent <= 1'b0;
    if (!rst_n) begin
      cnt <= 0;
    end else if (go && cnt == 0) begin
      in_token <= 1'b1;
      refused <= 1'b0;
      cnt <= 3 + gap;
    end else if (cnt > 0) begin
      if (stall_reply || zero_len_reply) refused <= 1'b1;
      // no data packet follows a stall or zero-length answer
      if (cnt == 1 && !refused && !stall_reply && !zero_len_reply) pkt_sent <= 1'b1;
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire
